//--- src/msmc_pkg.sv
package msmc_pkg;
  // ------------------------------------------------------------
  // Channel and timing
  // ------------------------------------------------------------
  localparam int NUM_CH = 8;
  localparam int NUM_OUT = 6;
  localparam int CLK_HZ = 10000000;
  localparam int HOLD_MS = 1000;
  localparam int HOLD_CYCLES = CLK_HZ / 1000 * HOLD_MS;
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;
  // ------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SEL = 8'h08;
  localparam logic [7:0] REG_PARAM = 8'h0C;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CTRL_ATTACH_BIT = 0;
  localparam int CTRL_HIRATE_BIT = 1;
  localparam int CTRL_SYNC_BIT = 2;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_SHIFT_BIT = 4;
  localparam int STAT_USER_BIT = 5;
  localparam int STAT_EQOK_BIT = 6;
  localparam int STAT_ROUTE_BIT = 7;
  localparam int STAT_TSOLO_LSB = 8;
  // ------------------------------------------------------------
  // Parameter limits, step sizes and reset values
  // ------------------------------------------------------------
  localparam logic [10:0] FREQ_MIN = 11'h003;
  localparam logic [10:0] FREQ_KNEE = 11'h3E8;
  localparam logic [10:0] FREQ_MAX = 11'h7D0;
  localparam logic [10:0] FREQ_RST = 11'h064;
  localparam logic [10:0] FREQ_FINE = 11'h001;
  localparam logic [10:0] FREQ_COARSE = 11'h00A;
  localparam logic signed [7:0] GAIN_MIN = -8'sh0C;
  localparam logic signed [7:0] GAIN_MAX = 8'sh0C;
  localparam logic [6:0] Q_MIN = 7'h01;
  localparam logic [6:0] Q_MAX = 7'h64;
  localparam logic [6:0] Q_RST = 7'h07;
  localparam logic signed [7:0] PAN_MIN = -8'sh12;
  localparam logic signed [7:0] PAN_MAX = 8'sh12;
  localparam logic signed [7:0] OUT_MIN = -8'sh28;
  localparam logic signed [7:0] OUT_MAX = 8'sh00;
  localparam logic signed [7:0] TRIM_MIN = -8'sh40;
  localparam logic signed [7:0] TRIM_MAX = 8'sh3F;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_TRIM = 3'h0,
    MODE_FREQ = 3'h1,
    MODE_GAIN = 3'h3,
    MODE_Q = 3'h2,
    MODE_PAN = 3'h6,
    MODE_OUT = 3'h7,
    MODE_USER = 3'h5
  } msmc_mode_type;
  typedef enum logic [1:0] {
    LED_OFF = 2'h0,
    LED_GREEN = 2'h1,
    LED_YELLOW = 2'h2,
    LED_RED = 2'h3
  } msmc_color_type;
  typedef struct packed {
    logic active;
    logic limit;
    logic clip;
  } msmc_meter_type;
  typedef struct packed {
    logic [10:0] freq;
    logic signed [7:0] gain;
    logic [6:0] q;
    logic bypass;
    logic signed [7:0] pan;
    logic signed [7:0] trim;
    logic solo;
  } msmc_chan_type;
endpackage

//--- src/msmc_param_ram.sv
`timescale 1ns/1ns
`default_nettype none
module msmc_param_ram (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wrEn,
  input wire logic [2:0] wrAddr,
  input wire msmc_pkg::msmc_chan_type wrData,
  input wire logic [2:0] rdAddr,
  output msmc_pkg::msmc_chan_type rdData
);
  import msmc_pkg::*;
  // ------------------------------------------------------------
  // Per-input settings store
  // ------------------------------------------------------------
  msmc_chan_type mem_r [NUM_CH];
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gEnt
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mem_r[g] <= '{freq: FREQ_RST, gain: 8'sh00, q: Q_RST, bypass: 1'b0, pan: 8'sh00, trim: 8'sh00,
                        solo: 1'b0};
        end else if (wrEn && wrAddr == 3'(g)) begin
          mem_r[g] <= wrData;
        end
      end
    end
  endgenerate
  // Registered read keeps the output a flop; one cycle latency
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= '0;
    end else begin
      rdData <= mem_r[rdAddr];
    end
  end
endmodule
`default_nettype wire

//--- src/msmc_top.sv
`timescale 1ns/1ns
`default_nettype none
module msmc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [3:0] modeButton,
  input wire logic shiftButton,
  input wire logic [msmc_pkg::NUM_CH-1:0] encPress,
  input wire logic [msmc_pkg::NUM_CH-1:0] encStep,
  input wire logic [msmc_pkg::NUM_CH-1:0] encUp,
  input wire logic [msmc_pkg::NUM_CH-1:0] trackButton,
  input wire logic [msmc_pkg::NUM_CH-1:0] gainKnobOn,
  input wire msmc_pkg::msmc_meter_type [msmc_pkg::NUM_CH-1:0] inMeter,
  input wire logic [msmc_pkg::NUM_CH-1:0] inMute,
  input wire msmc_pkg::msmc_meter_type [msmc_pkg::NUM_CH-1:0] outMeter,
  output msmc_pkg::msmc_color_type [msmc_pkg::NUM_CH-1:0] ringLed,
  output logic [3:0] modeLedGreen,
  output logic [3:0] modeLedBlue,
  output logic shiftLedBlue,
  output logic [msmc_pkg::NUM_CH-1:0] inputEnable,
  output logic [msmc_pkg::NUM_CH-1:0] eqActive,
  output logic [msmc_pkg::NUM_CH-1:0] panActive,
  output logic [msmc_pkg::NUM_OUT-1:0] outMute,
  output logic [msmc_pkg::NUM_OUT-1:0] outSolo,
  output logic [msmc_pkg::NUM_CH-1:0] trackSolo,
  output logic routingMode,
  output logic [1:0] userSel
);
  import msmc_pkg::*;
  // ------------------------------------------------------------
  // Control register and bus slave
  // ------------------------------------------------------------
  // Buttons: [0] eq_frequency_mode_button, [1] mode_button_a, [2] pan, [3] output
  logic [2:0] ctrl_r;
  logic [2:0] sel_r;
  logic attached, hiRate, syncOk, attachRise, attachPrev_r, rdPend_r;
  msmc_mode_type mode_r;
  logic shiftArmed_r, userAct_r;
  logic [1:0] userSel_r;
  msmc_chan_type rdData, wrData;
  logic wrEn;
  logic [2:0] wrAddr;
  assign attached = ctrl_r[CTRL_ATTACH_BIT];
  assign hiRate = ctrl_r[CTRL_HIRATE_BIT];
  assign syncOk = ctrl_r[CTRL_SYNC_BIT];
  assign attachRise = attached && !attachPrev_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= 3'h0;
      sel_r <= 3'h0;
    end else if (avs_write && !avs_waitrequest && avs_byteenable[0]) begin
      if (avs_address == REG_CTRL) begin
        ctrl_r <= avs_writedata[2:0];
      end else if (avs_address == REG_SEL) begin
        sel_r <= avs_writedata[2:0];
      end
    end
  end
  // Reads take two cycles so the settings store can answer from its register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdPend_r <= 1'b0;
    end else begin
      // Only a read still waiting may borrow the store's port, never the accept cycle
      rdPend_r <= avs_read && !rdPend_r && avs_waitrequest;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_write && avs_waitrequest) || (avs_read && rdPend_r && avs_waitrequest));
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && rdPend_r) begin
      if (avs_address == REG_CTRL) begin
        avs_readdata <= {29'h0, ctrl_r};
      end else if (avs_address == REG_STATUS) begin
        avs_readdata <= {16'h0, trackSolo, routingMode, !hiRate && attached, userAct_r, shiftArmed_r, 1'b0, mode_r};
      end else if (avs_address == REG_SEL) begin
        avs_readdata <= {29'h0, sel_r};
      end else if (avs_address == REG_PARAM) begin
        avs_readdata <= {rdData.freq, rdData.gain[4:0], rdData.q, rdData.bypass, rdData.pan[5:0], rdData.solo,
                         1'b0};
      end else begin
        avs_readdata <= 32'h0;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      attachPrev_r <= 1'b0;
    end else begin
      attachPrev_r <= attached;
    end
  end
  // ------------------------------------------------------------
  // Mode selection
  // ------------------------------------------------------------
  logic [3:0] btnPrev_r;
  logic shiftPrev_r;
  logic [3:0] btnRise;
  assign btnRise = modeButton & ~btnPrev_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      btnPrev_r <= 4'h0;
      shiftPrev_r <= 1'b0;
    end else begin
      btnPrev_r <= modeButton;
      shiftPrev_r <= shiftButton;
    end
  end
  function automatic msmc_mode_type btnMode(input logic [1:0] idx);
    case (idx)
      2'h0: btnMode = MODE_FREQ;
      2'h1: btnMode = MODE_GAIN;
      2'h2: btnMode = MODE_PAN;
      default: btnMode = MODE_OUT;
    endcase
  endfunction
  logic [1:0] pressIdx;
  always_comb begin
    pressIdx = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (btnRise[i]) begin
        pressIdx = 2'(i);
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= MODE_TRIM;
      userAct_r <= 1'b0;
      userSel_r <= 2'h0;
      shiftArmed_r <= 1'b0;
    end else if (attachRise || !attached) begin
      mode_r <= MODE_TRIM;
      userAct_r <= 1'b0;
      shiftArmed_r <= 1'b0;
    end else begin
      if (modeButton[1:0] == 2'b11 && btnRise[1:0] != 2'b00) begin
        mode_r <= (mode_r == MODE_Q) ? MODE_TRIM : MODE_Q;
        userAct_r <= 1'b0;
        shiftArmed_r <= 1'b0;
      end else if (btnRise != 4'h0) begin
        shiftArmed_r <= 1'b0;
        if (shiftArmed_r) begin
          if (userAct_r && userSel_r == pressIdx) begin
            mode_r <= MODE_TRIM;
            userAct_r <= 1'b0;
          end else begin
            mode_r <= MODE_USER;
            userAct_r <= 1'b1;
            userSel_r <= pressIdx;
          end
        end else if ((!userAct_r && mode_r == btnMode(pressIdx)) || (userAct_r && userSel_r == pressIdx)) begin
          mode_r <= MODE_TRIM;
          userAct_r <= 1'b0;
        end else begin
          mode_r <= btnMode(pressIdx);
          userAct_r <= 1'b0;
        end
      end
      // Last, so a shift release meeting a mode press in one cycle still arms
      if (shiftPrev_r && !shiftButton) begin
        shiftArmed_r <= 1'b1;
      end
    end
  end
  // ------------------------------------------------------------
  // Encoder press timing, short versus hold
  // ------------------------------------------------------------
  // One shared scan would be smaller, but per-channel timers keep holds independent
  logic [NUM_CH-1:0] shortEv, holdEv, trkHoldEv;
  logic [NUM_CH-1:0] encPrev_r;
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gPress
      logic [23:0] cnt_r, tcnt_r;
      logic done_r, tdone_r;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt_r <= 24'h0;
          done_r <= 1'b0;
        end else if (!encPress[g]) begin
          cnt_r <= 24'h0;
          done_r <= 1'b0;
        end else if (!done_r && cnt_r == 24'(HOLD_CYCLES - 1)) begin
          done_r <= 1'b1;
        end else if (!done_r) begin
          cnt_r <= cnt_r + 24'h1;
        end
      end
      assign holdEv[g] = encPress[g] && !done_r && cnt_r == 24'(HOLD_CYCLES - 1);
      assign shortEv[g] = encPrev_r[g] && !encPress[g] && !done_r;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          tcnt_r <= 24'h0;
          tdone_r <= 1'b0;
        end else if (!trackButton[g]) begin
          tcnt_r <= 24'h0;
          tdone_r <= 1'b0;
        end else if (!tdone_r && tcnt_r == 24'(HOLD_CYCLES - 1)) begin
          tdone_r <= 1'b1;
        end else if (!tdone_r) begin
          tcnt_r <= tcnt_r + 24'h1;
        end
      end
      assign trkHoldEv[g] = trackButton[g] && !tdone_r && tcnt_r == 24'(HOLD_CYCLES - 1);
    end
  endgenerate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      encPrev_r <= '0;
    end else begin
      encPrev_r <= encPress;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trackSolo <= '0;
      routingMode <= 1'b0;
    end else if (!attached) begin
      trackSolo <= '0;
      routingMode <= 1'b0;
    end else if (trkHoldEv != '0) begin
      trackSolo <= trackSolo ^ trkHoldEv;
      routingMode <= 1'b1;
    end else if (btnRise != 4'h0) begin
      routingMode <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // Per-input setting update, one channel per cycle
  // ------------------------------------------------------------
  logic [2:0] scan_r;
  logic [2:0] rdAddr;
  logic [NUM_CH-1:0] pendTurn_r, pendUp_r, pendShort_r, pendHold_r;
  logic isEq;
  msmc_chan_type nxt;
  assign isEq = mode_r == MODE_FREQ || mode_r == MODE_GAIN || mode_r == MODE_Q;
  assign rdAddr = (avs_read && !rdPend_r && avs_waitrequest) ? sel_r : scan_r + 3'h1;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_r <= 3'h0;
    end else if (!(avs_read && !rdPend_r && avs_waitrequest)) begin
      scan_r <= scan_r + 3'h1;
    end
  end
  // Events latch until the scan reaches their channel; a new event wins over the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pendTurn_r <= '0;
      pendUp_r <= '0;
      pendShort_r <= '0;
      pendHold_r <= '0;
    end else if (!attached || mode_r == MODE_OUT) begin
      // Presses met in output mode or while detached belong to no input setting
      pendTurn_r <= '0;
      pendShort_r <= '0;
      pendHold_r <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (wrEn && wrAddr == 3'(i)) begin
          pendTurn_r[i] <= encStep[i];
          pendShort_r[i] <= shortEv[i];
          pendHold_r[i] <= holdEv[i];
        end else begin
          pendTurn_r[i] <= pendTurn_r[i] | encStep[i];
          pendShort_r[i] <= pendShort_r[i] | shortEv[i];
          pendHold_r[i] <= pendHold_r[i] | holdEv[i];
        end
        if (encStep[i]) begin
          pendUp_r[i] <= encUp[i];
        end
      end
    end
  end
  assign wrAddr = scan_r;
  assign wrEn = !rdPend_r && attached && mode_r != MODE_OUT;
  always_comb begin
    nxt = rdData;
    if (pendTurn_r[scan_r]) begin
      case (mode_r)
        MODE_TRIM: begin
          if (pendUp_r[scan_r] && rdData.trim < TRIM_MAX) nxt.trim = rdData.trim + 8'sh01;
          if (!pendUp_r[scan_r] && rdData.trim > TRIM_MIN) nxt.trim = rdData.trim - 8'sh01;
        end
        MODE_FREQ: begin
          if (pendUp_r[scan_r] && rdData.freq < FREQ_MAX) begin
            nxt.freq = rdData.freq + ((rdData.freq < FREQ_KNEE) ? FREQ_FINE : FREQ_COARSE);
          end
          if (!pendUp_r[scan_r] && rdData.freq > FREQ_MIN) begin
            nxt.freq = rdData.freq - ((rdData.freq <= FREQ_KNEE) ? FREQ_FINE : FREQ_COARSE);
          end
        end
        MODE_GAIN: begin
          if (pendUp_r[scan_r] && rdData.gain < GAIN_MAX) nxt.gain = rdData.gain + 8'sh01;
          if (!pendUp_r[scan_r] && rdData.gain > GAIN_MIN) nxt.gain = rdData.gain - 8'sh01;
        end
        MODE_Q: begin
          if (pendUp_r[scan_r] && rdData.q < Q_MAX) nxt.q = rdData.q + 7'h01;
          if (!pendUp_r[scan_r] && rdData.q > Q_MIN) nxt.q = rdData.q - 7'h01;
        end
        MODE_PAN: begin
          if (pendUp_r[scan_r] && rdData.pan < PAN_MAX) nxt.pan = rdData.pan + 8'sh01;
          if (!pendUp_r[scan_r] && rdData.pan > PAN_MIN) nxt.pan = rdData.pan - 8'sh01;
        end
        default: nxt = rdData;
      endcase
    end
    if (pendShort_r[scan_r]) nxt.solo = !rdData.solo;
    if (pendHold_r[scan_r] && isEq) nxt.bypass = !rdData.bypass;
  end
  assign wrData = nxt;
  msmc_param_ram uRam (
    .clk(clk),
    .rst_n(rst_n),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .rdAddr(rdAddr),
    .rdData(rdData)
  );
  // ------------------------------------------------------------
  // Per-input outputs and output channels
  // ------------------------------------------------------------
  logic [NUM_CH-1:0] soloSh_r, bypassSh_r;
  logic signed [7:0] outLvl_r [NUM_OUT];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soloSh_r <= '0;
      bypassSh_r <= '0;
    end else if (wrEn) begin
      soloSh_r[wrAddr] <= nxt.solo;
      bypassSh_r[wrAddr] <= nxt.bypass;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eqActive <= '0;
      panActive <= '0;
      inputEnable <= '0;
    end else begin
      eqActive <= (attached && !hiRate) ? ~bypassSh_r : '0;
      panActive <= attached ? '1 : '0;
      inputEnable <= gainKnobOn;
    end
  end
  generate
    for (g = 0; g < NUM_OUT; g++) begin : gOut
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          outMute[g] <= 1'b0;
          outSolo[g] <= 1'b0;
          outLvl_r[g] <= OUT_MAX;
        end else if (!attached) begin
          outMute[g] <= 1'b0;
          outSolo[g] <= 1'b0;
        end else if (mode_r == MODE_OUT) begin
          if (holdEv[g]) outMute[g] <= !outMute[g];
          if (shortEv[g]) outSolo[g] <= !outSolo[g];
          if (encStep[g] && encUp[g] && outLvl_r[g] < OUT_MAX) outLvl_r[g] <= outLvl_r[g] + 8'sh01;
          if (encStep[g] && !encUp[g] && outLvl_r[g] > OUT_MIN) outLvl_r[g] <= outLvl_r[g] - 8'sh01;
        end
      end
    end
  endgenerate
  // ------------------------------------------------------------
  // LEDs
  // ------------------------------------------------------------
  logic [21:0] blinkCnt_r;
  logic blink_r;
  logic [NUM_CH-1:0] outMuteWide, outSoloWide;
  // Widened so the ring loop may index the two channels without an output
  assign outMuteWide = {{(NUM_CH - NUM_OUT){1'b0}}, outMute};
  assign outSoloWide = {{(NUM_CH - NUM_OUT){1'b0}}, outSolo};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blinkCnt_r <= 22'h0;
      blink_r <= 1'b0;
    end else if (blinkCnt_r == 22'(BLINK_CYCLES - 1)) begin
      blinkCnt_r <= 22'h0;
      blink_r <= !blink_r;
    end else begin
      blinkCnt_r <= blinkCnt_r + 22'h1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modeLedGreen <= 4'h0;
      modeLedBlue <= 4'h0;
      shiftLedBlue <= 1'b0;
      userSel <= 2'h0;
    end else begin
      modeLedGreen <= 4'h0;
      modeLedBlue <= 4'h0;
      shiftLedBlue <= shiftArmed_r && blink_r;
      userSel <= userSel_r;
      case (mode_r)
        MODE_FREQ: modeLedGreen <= {3'h0, blink_r};
        MODE_GAIN: modeLedGreen <= {2'h0, blink_r, 1'b0};
        MODE_Q: modeLedGreen <= {2'h0, blink_r, blink_r};
        MODE_PAN: modeLedGreen <= {1'b0, blink_r, 2'h0};
        MODE_OUT: modeLedGreen <= {blink_r, 3'h0};
        MODE_USER: modeLedBlue <= 4'(blink_r) << userSel_r;
        default: modeLedGreen <= 4'h0;
      endcase
    end
  end
  generate
    for (g = 0; g < NUM_CH; g++) begin : gRing
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          ringLed[g] <= LED_OFF;
        end else if (!syncOk) begin
          ringLed[g] <= blink_r ? LED_YELLOW : LED_OFF;
        end else if (mode_r == MODE_OUT) begin
          if (g >= NUM_OUT) ringLed[g] <= LED_OFF;
          else if (outMuteWide[g]) ringLed[g] <= LED_RED;
          else if (outSoloWide[g]) ringLed[g] <= LED_YELLOW;
          else if (outMeter[g].clip) ringLed[g] <= LED_RED;
          else if (outMeter[g].active) ringLed[g] <= LED_GREEN;
          else ringLed[g] <= LED_OFF;
        end else begin
          if (inMute[g]) ringLed[g] <= LED_RED;
          else if (soloSh_r[g]) ringLed[g] <= LED_YELLOW;
          else if (inMeter[g].clip) ringLed[g] <= LED_RED;
          else if (inMeter[g].limit) ringLed[g] <= LED_YELLOW;
          else if (inMeter[g].active) ringLed[g] <= LED_GREEN;
          else ringLed[g] <= LED_OFF;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

//--- testbench/msmc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module msmc_host_model (
  input wire logic [7:0] muteReq,
  output var msmc_pkg::msmc_meter_type [7:0] inMeter,
  output logic [7:0] inMute,
  output var msmc_pkg::msmc_meter_type [7:0] outMeter
);
  import msmc_pkg::*;
  // Steady activity only, so a stray clip colour shows up at once
  assign inMute = muteReq;
  assign inMeter = {8{3'h4}};
  assign outMeter = {8{3'h4}};
endmodule
`default_nettype wire

//--- testbench/msmc_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module msmc_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [7:0] trackButton,
  input wire logic [7:0] trackSolo,
  input wire logic [7:0] gainKnobOn,
  input wire logic [7:0] inputEnable,
  input wire logic [7:0] eqActive,
  input wire logic [7:0] panActive,
  input wire logic routingMode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence acceptS;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  wait_pulse_a: assert property ($fell(avs_waitrequest) |-> acceptS) else $error("accept too long");
  wait_cause_a: assert property (!avs_waitrequest |-> avs_read || avs_write) else $error("stray accept");
  wait_lead_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write)) else $error("early accept");
  rd_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read)) else $error("readdata moved");
  knob_copy_a: assert property (1'b1 |=> inputEnable == $past(gainKnobOn)) else $error("knob copy");
  eq_pan_a: assert property ((eqActive & ~panActive) == 8'h00) else $error("eq without pan");
  route_cause_a: assert property ($rose(routingMode) |-> $past(|trackButton)) else $error("routing cause");
  solo_cause_a: assert property ((trackSolo & ~$past(trackSolo) & ~$past(trackButton)) == 8'h00)
    else $error("track solo cause");
endmodule
bind msmc_top msmc_monitor mon (.clk, .rst_n, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .trackButton, .trackSolo, .gainKnobOn, .inputEnable, .eqActive, .panActive, .routingMode);
`default_nettype wire

//--- testbench/mixer_surface_mode_controller_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module mixer_surface_mode_controller_tb_top;
  import msmc_pkg::*;
  logic clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, shiftButton = 0, avs_waitrequest, routingMode, shiftLedBlue;
  logic [31:0] avs_readdata, q, avs_writedata = 0;
  logic [7:0] avs_address = 0, muteReq = 8'h08, gainKnobOn = 8'hA5, encPress = 0, encStep = 0, encUp = 0;
  logic [7:0] trackButton = 0, inputEnable, eqActive, panActive, trackSolo, inMute;
  logic [3:0] avs_byteenable = 4'hF, modeButton = 0, modeLedGreen, modeLedBlue;
  logic [5:0] outMute, outSolo;
  logic [1:0] userSel;
  msmc_meter_type [7:0] inMeter, outMeter;
  msmc_color_type [7:0] ringLed;
  int errors = 0, check_count = 0, cyc = 0;
  always #50 clk = ~clk;
  msmc_host_model host (.muteReq, .inMeter, .inMute, .outMeter);
  msmc_top dut (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .modeButton, .shiftButton, .encPress, .encStep, .encUp, .trackButton, .gainKnobOn, .inMeter,
    .inMute, .outMeter, .ringLed, .modeLedGreen, .modeLedBlue, .shiftLedBlue, .inputEnable, .eqActive, .panActive,
    .outMute, .outSolo, .trackSolo, .routingMode, .userSel);
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      complete_run;
    end
  end
  task complete_run;
    if (errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
  endtask
  task btn(input logic [3:0] m, input logic s);
    modeButton <= m;
    shiftButton <= s;
    repeat (4) @(posedge clk);
    modeButton <= 0;
    shiftButton <= 0;
    repeat (20) @(posedge clk);
  endtask
  task md(input logic [2:0] e);
    bus(0, REG_STATUS, 0);
    chk(q[2:0], e);
  endtask
  task step;
    encStep[0] <= 1;
    encUp[0] <= 1;
    @(posedge clk);
    encStep <= 0;
    repeat (20) @(posedge clk);
    bus(0, REG_PARAM, 0);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    md(MODE_TRIM);
    chk({modeLedGreen, modeLedBlue}, 0);
    bus(1, REG_CTRL, 5);
    bus(1, REG_SEL, 0);
    btn(1, 0);
    md(MODE_FREQ);
    chk({q[STAT_EQOK_BIT], eqActive, panActive}, 17'h1FFFF);
    step;
    chk(q[31:21], FREQ_RST + FREQ_FINE);
    btn(1, 0);
    md(MODE_TRIM);
    btn(3, 0);
    md(MODE_Q);
    step;
    chk(q[15:9], Q_RST + 7'h01);
    btn(4, 0);
    md(MODE_PAN);
    btn(0, 1);
    btn(2, 0);
    md(MODE_USER);
    chk({q[STAT_USER_BIT], userSel}, 3'h5);
    btn(8, 0);
    md(MODE_OUT);
    encPress <= 8'h84;
    repeat (4) @(posedge clk);
    encPress <= 0;
    repeat (20) @(posedge clk);
    chk(outSolo, 6'h04);
    chk({ringLed[7], ringLed[2]}, 4'h2);
    bus(1, REG_CTRL, 4);
    repeat (20) @(posedge clk);
    md(MODE_TRIM);
    chk({outSolo, panActive, ringLed[3]}, LED_RED);
    bus(1, REG_CTRL, 7);
    repeat (20) @(posedge clk);
    bus(1, REG_SEL, 7);
    bus(0, REG_PARAM, 0);
    chk(q[1], 1'b0);
    bus(0, REG_STATUS, 0);
    chk({q[STAT_EQOK_BIT], eqActive, inputEnable}, 9'h0A5);
    bus(0, 8'h10, 0);
    chk(q, 0);
    complete_run;
  end
endmodule
`default_nettype wire
